//--- rtl/sps_consts.svh
// register map, field positions, reset values and counts of the slave port
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

`define SPS_OFF_CTRL 8'h00
`define SPS_OFF_STAT 8'h04
`define SPS_OFF_BUF 8'h08
`define SPS_OFF_APF 8'h0c
`define SPS_OFF_IRQ 8'h10
`define SPS_OFF_MASK 8'h14

`define SPS_CTRL_WRITE_COLLISION_FLAG 7
`define SPS_CTRL_OVF 6
`define SPS_CTRL_EN 5
`define SPS_CTRL_CKP 4
`define SPS_MODE_SS 4'h4
`define SPS_MODE_NOSS 4'h5

`define SPS_STAT_SMP 7
`define SPS_STAT_CKE 6
`define SPS_STAT_BF 0
`define SPS_APF_SEL 1

`define SPS_IRQ_DONE 0
`define SPS_IRQ_WRITE_COLLISION_FLAG 1
`define SPS_IRQ_OVF 2

`define SPS_CTRL_RST 8'h00
`define SPS_LAST_BIT 3'h7
`define SPS_SYNC_STAGES 2

`endif

//--- rtl/sps_pkg.sv
// types shared by the slave port design
package sps_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sps_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sps_wb_rsp_s;

  typedef struct packed {
    logic sck;
    logic serial_in_pin;
    logic ss_a_n;
    logic ss_b_n;
  } sps_pin_in_s;

  typedef struct packed {
    logic serial_out_pin;
    logic sdo_oe;
    logic pins_active;
  } sps_pin_out_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic sample_phase_select;
    logic cke;
    logic bf;
    logic apf_sel;
    logic [7:0] sr;
    logic [7:0] rxbuf;
    logic [2:0] cnt;
    logic sck_d;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    sps_wb_rsp_s wb;
    sps_pin_out_s pin;
    logic irq;
    logic wake;
  } sps_state_s;

endpackage

//--- rtl/sps_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sps_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

//--- rtl/sps_spi_slave.sv
// byte-wide spi slave port with optional slave select and wishbone registers
`timescale 1ns/1ps
`include "sps_consts.svh"

module sps_spi_slave
  import sps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire sps_wb_req_s wb_req,
  output sps_wb_rsp_s wb_rsp,
  input wire sps_pin_in_s pin_in,
  output sps_pin_out_s pin_out,
  input wire logic sleep_mode,
  output logic irq,
  output logic wake
);

  // ----------------------------------------------------------------
  // state and decode helpers
  // ----------------------------------------------------------------
  localparam sps_state_s ST_RST = '0;

  sps_state_s st_r;
  sps_state_s st_nxt;
  sps_pin_in_s pin_s;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins cross into the register clock
  sps_sync #(
    .W($bits(sps_pin_in_s))
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .d(pin_in),
    .q(pin_s)
  );

  // ----------------------------------------------------------------
  // mode and edge decode
  // ----------------------------------------------------------------
  logic [3:0] mode;
  logic en;
  logic slave;
  logic ss_n;
  logic mod_rst;
  logic active;
  logic sck_edge;
  logic lead;
  logic trail;
  logic samp;
  logic chg;
  logic done;
  logic acc;
  logic wr;
  logic rd;
  logic buf_wr;
  logic busy;

  assign mode = st_r.ctrl[3:0];
  assign en = st_r.ctrl[`SPS_CTRL_EN];
  // only the two slave codes claim the pins
  assign slave = (mode == `SPS_MODE_SS) || (mode == `SPS_MODE_NOSS);
  assign ss_n = st_r.apf_sel ? pin_s.ss_b_n : pin_s.ss_a_n;
  // select only counts in the select mode
  assign mod_rst = !en || ((mode == `SPS_MODE_SS) && ss_n);
  // disabled or non-slave port stays idle
  assign active = en && slave && !mod_rst;
  assign sck_edge = pin_s.sck ^ st_r.sck_d;
  // leading edge leaves the idle level
  assign lead = sck_edge && (st_r.sck_d == st_r.ctrl[`SPS_CTRL_CKP]);
  assign trail = sck_edge && (st_r.sck_d != st_r.ctrl[`SPS_CTRL_CKP]);
  assign samp = active && !st_r.ctrl[`SPS_CTRL_OVF] && (st_r.cke ? lead : trail);
  assign chg = active && !st_r.ctrl[`SPS_CTRL_OVF] && (st_r.cke ? trail : lead);
  assign done = samp && (st_r.cnt == `SPS_LAST_BIT);
  assign busy = (st_r.cnt != 3'h0);

  assign acc = wb_req.cyc && wb_req.stb && !st_r.wb.ack;
  assign wr = acc && wb_req.we && wb_req.sel[0];
  assign rd = acc && !wb_req.we;
  assign buf_wr = wr && hit(wb_req.adr, `SPS_OFF_BUF);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_d = pin_s.sck;
    st_nxt.wb.ack = acc;
    st_nxt.wb.dat = 32'h0;

    if (mod_rst) begin
      st_nxt.cnt = 3'h0;
    end
    // shifter content is void after a module reset mid-byte
    if (mod_rst && busy) begin
      st_nxt.sr = 8'h00;
    end

    // serial out changes on the opposite edge to sampling
    if (chg) begin
      st_nxt.pin.serial_out_pin = st_r.sr[7];
    end
    if (samp) begin
      st_nxt.sr = {st_r.sr[6:0], pin_s.serial_in_pin};
      st_nxt.cnt = st_r.cnt + 3'h1;
    end

    // register reads
    if (rd) begin
      if (hit(wb_req.adr, `SPS_OFF_CTRL)) begin
        st_nxt.wb.dat = {24'h0, st_r.ctrl};
      end else if (hit(wb_req.adr, `SPS_OFF_STAT)) begin
        st_nxt.wb.dat = {24'h0, st_r.sample_phase_select, st_r.cke, 5'h00, st_r.bf};
      end else if (hit(wb_req.adr, `SPS_OFF_BUF)) begin
        st_nxt.wb.dat = {24'h0, st_r.rxbuf};
        st_nxt.bf = 1'b0;
      end else if (hit(wb_req.adr, `SPS_OFF_APF)) begin
        st_nxt.wb.dat = {30'h0, st_r.apf_sel, 1'b0};
      end else if (hit(wb_req.adr, `SPS_OFF_IRQ)) begin
        st_nxt.wb.dat = {29'h0, st_r.irq_st};
        st_nxt.irq_st = 3'h0;
      end else if (hit(wb_req.adr, `SPS_OFF_MASK)) begin
        st_nxt.wb.dat = {29'h0, st_r.irq_mask};
      end
    end

    // register writes
    if (wr) begin
      if (hit(wb_req.adr, `SPS_OFF_CTRL)) begin
        st_nxt.ctrl = wb_req.dat[7:0];
      end else if (hit(wb_req.adr, `SPS_OFF_STAT)) begin
        st_nxt.sample_phase_select = wb_req.dat[`SPS_STAT_SMP];
        st_nxt.cke = wb_req.dat[`SPS_STAT_CKE];
      end else if (hit(wb_req.adr, `SPS_OFF_APF)) begin
        st_nxt.apf_sel = wb_req.dat[`SPS_APF_SEL];
      end else if (hit(wb_req.adr, `SPS_OFF_MASK)) begin
        st_nxt.irq_mask = wb_req.dat[2:0];
      end
    end

    if (buf_wr && busy && !mod_rst) begin
      st_nxt.ctrl[`SPS_CTRL_WRITE_COLLISION_FLAG] = 1'b1;
      st_nxt.irq_st[`SPS_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
    end else if (buf_wr) begin
      st_nxt.sr = wb_req.dat[7:0];
      st_nxt.pin.serial_out_pin = wb_req.dat[7];
      st_nxt.cnt = 3'h0;
    end

    // completed byte lands in the buffer
    if (done && !st_r.bf) begin
      st_nxt.rxbuf = {st_r.sr[6:0], pin_s.serial_in_pin};
      st_nxt.bf = 1'b1;
    end
    // byte arriving on a full buffer overflows
    if (done && st_r.bf) begin
      st_nxt.ctrl[`SPS_CTRL_OVF] = 1'b1;
      st_nxt.irq_st[`SPS_IRQ_OVF] = 1'b1;
    end
    // each full byte raises the port flag
    if (done) begin
      st_nxt.irq_st[`SPS_IRQ_DONE] = 1'b1;
    end

    // serial out driven only while active; select gates it only in the select mode
    st_nxt.pin.sdo_oe = active;
    st_nxt.pin.pins_active = en && slave;
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
    // wake on a full byte when enabled
    st_nxt.wake = sleep_mode && st_nxt.irq_st[`SPS_IRQ_DONE]
                  && st_nxt.irq_mask[`SPS_IRQ_DONE];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign wb_rsp = st_r.wb;
  assign pin_out = st_r.pin;
  assign irq = st_r.irq;
  assign wake = st_r.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack && ce;
  endsequence

  sequence s_ack_pulse;
    wb_rsp.ack ##1 !wb_rsp.ack;
  endsequence

  a_ack_single: assert property (s_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse");

  function automatic logic irq_st_done();
    irq_st_done = st_r.irq_st[`SPS_IRQ_DONE];
  endfunction

  a_bf_on_done: assert property (ce && done && !st_r.bf |=> st_r.bf && irq_st_done())
    else $error("buffer full not set after byte");

  a_ovf_on_full: assert property (ce && done && st_r.bf |=> st_r.ctrl[`SPS_CTRL_OVF])
    else $error("overflow not flagged");

  a_write_collision_flag_on_busy: assert property (ce && buf_wr && busy && !mod_rst
    |=> st_r.ctrl[`SPS_CTRL_WRITE_COLLISION_FLAG])
    else $error("write collision not flagged");

  a_sdo_tristate: assert property (ce && en && (mode == `SPS_MODE_SS) && ss_n
    |=> !pin_out.sdo_oe)
    else $error("serial out driven while deselected");

  a_cnt_cleared: assert property (ce && mod_rst && !buf_wr |=> st_r.cnt == 3'h0)
    else $error("bit counter not cleared on module reset");

  a_pins_released: assert property (ce && !en |=> !pin_out.pins_active && !pin_out.sdo_oe)
    else $error("pins held while disabled");

  a_wake_on_byte: assert property (ce && done && sleep_mode
    && st_r.irq_mask[`SPS_IRQ_DONE] |=> wake)
    else $error("no wake after byte in sleep");

  a_sleep_shift: assert property (ce && samp && sleep_mode && !buf_wr
    |=> st_r.cnt == ($past(st_r.cnt) + 3'h1))
    else $error("shifting stalled in sleep");

  a_sel_route: assert property (ce && en && (mode == `SPS_MODE_SS)
    && st_r.apf_sel && pin_s.ss_b_n |=> !pin_out.sdo_oe)
    else $error("alternate select pin not honoured");

  // ----------------------------------------------------------------
  // data path and flag checks
  // ----------------------------------------------------------------
  sequence s_buf_load;
    ce && buf_wr && !(busy && !mod_rst);
  endsequence

  sequence s_sel_sample;
    ce && en && (mode == `SPS_MODE_SS) && !ss_n && samp && !buf_wr;
  endsequence

  a_ack_dat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("read data not zero outside ack");

  a_rxbuf_load: assert property (ce && done && !st_r.bf
    |=> (st_r.rxbuf[7:1] == $past(st_r.sr[6:0])) && (st_r.rxbuf[0] == $past(pin_s.serial_in_pin)))
    else $error("received byte not moved to buffer");

  a_bf_rd_clear: assert property (ce && rd && (wb_req.adr == `SPS_OFF_BUF) && !done
    |=> !st_r.bf)
    else $error("buffer full not cleared by read");

  a_write_collision_flag_sticky: assert property (ce && st_r.ctrl[`SPS_CTRL_WRITE_COLLISION_FLAG] && !wr
    |=> st_r.ctrl[`SPS_CTRL_WRITE_COLLISION_FLAG])
    else $error("write collision flag lost");

  a_ovf_halts: assert property (st_r.ctrl[`SPS_CTRL_OVF] |-> !samp && !chg)
    else $error("shifting after overflow");

  a_irq_level: assert property (irq == |(st_r.irq_st & st_r.irq_mask))
    else $error("interrupt level wrong");

  a_done_flag: assert property (ce && done |=> st_r.irq_st[`SPS_IRQ_DONE])
    else $error("port flag not set after byte");

  a_no_wake_awake: assert property (ce && !sleep_mode |=> !wake)
    else $error("wake raised while awake");

  a_disabled_idle: assert property (ce && !en |=> st_r.cnt == 3'h0)
    else $error("bit counter moved while disabled");

  a_oe_claimed: assert property (pin_out.sdo_oe |-> pin_out.pins_active)
    else $error("serial out driven without pins claimed");

  a_nonslave_free: assert property (ce && !slave |=> !pin_out.pins_active)
    else $error("pins claimed outside slave modes");

  a_noss_drive: assert property (ce && en && (mode == `SPS_MODE_NOSS)
    |=> pin_out.sdo_oe)
    else $error("select honoured outside select mode");

  a_sel_shift: assert property (s_sel_sample |=> st_r.sr[0] == $past(pin_s.serial_in_pin))
    else $error("no shifting while selected");

  a_buf_reload: assert property (s_buf_load |=> st_r.sr == $past(wb_req.dat[7:0]))
    else $error("buffer write did not reload shifter");

  a_modrst_void: assert property (ce && mod_rst && busy && !buf_wr
    |=> st_r.sr == 8'h00)
    else $error("shifter kept after module reset");

endmodule

//--- verif/sps_spi_master.sv
// external spi master model driving clock, data and select
`timescale 1ns/1ps
module sps_spi_master (
  output logic sck,
  output logic serial_in_pin,
  output logic ss_n,
  input wire logic serial_out_pin
);
  // ----------------
  // frame
  // ----------------
  initial begin
    sck = 1'b0;
    serial_in_pin = 1'b0;
    ss_n = 1'b1;
  end
  // idle low clock, sample on leading edge
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    ss_n = 1'b0;
    #64;
    for (int i = 0; i < nb; i++) begin
      serial_in_pin = tx[7 - i];
      #32 sck = 1'b1;
      rx = {rx[6:0], serial_out_pin};
      #32 sck = 1'b0;
    end
    #64 ss_n = 1'b1;
    // released data line shows the inverse of its last value
    serial_in_pin = ~serial_in_pin;
  endtask
endmodule

//--- verif/tb_sps_spi_slave.sv
// self-checking bench for the spi slave port
`timescale 1ns/1ps
`include "sps_consts.svh"
module tb_sps_spi_slave
  import sps_pkg::*;
;
  // ----------------
  // harness
  // ----------------
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sleep_mode = 1'b0;
  logic sel_b = 1'b0;
  logic ce = 1'b1;
  sps_wb_req_s wb_req = '0;
  sps_wb_rsp_s wb_rsp;
  sps_pin_out_s pin_out;
  sps_pin_in_s pin_in;
  logic irq, wake, sck, serial_in_pin, ss_n;
  logic [31:0] rd;
  logic [7:0] rx;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  // rows: byte from master, byte preloaded in the slave
  logic [15:0] rows [4] = '{16'ha53c, 16'h00ff, 16'hff00, 16'h817e};

  initial forever #4 clk_sys = ~clk_sys;
  assign pin_in = {sck, serial_in_pin, sel_b | ss_n, ~sel_b | ss_n};

  sps_spi_slave i_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .pin_in(pin_in), .pin_out(pin_out), .sleep_mode(sleep_mode),
    .irq(irq), .wake(wake));
  sps_spi_master i_master (.sck(sck), .serial_in_pin(serial_in_pin), .ss_n(ss_n),
    .serial_out_pin(pin_out.sdo_oe ? pin_out.serial_out_pin : 1'b1));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
    do begin
      @(posedge clk_sys);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    wb(1'b0, `SPS_OFF_CTRL, 8'h00);
    chk("ctrl reset", 32'h0, rd);
    wb(1'b1, `SPS_OFF_STAT, 8'h40);
    wb(1'b1, `SPS_OFF_MASK, 8'h07);
    wb(1'b1, `SPS_OFF_CTRL, 8'h24);
    foreach (rows[i]) begin
      wb(1'b1, `SPS_OFF_BUF, rows[i][7:0]);
      i_master.xfer(rows[i][15:8], 8, rx);
      chk("sdo byte", rows[i][7:0], rx);
      chk("irq", 1, irq);
      wb(1'b0, `SPS_OFF_STAT, 8'h0);
      chk("status", 32'h41, rd);
      wb(1'b0, `SPS_OFF_IRQ, 8'h0);
      chk("irq status", 32'h1, rd);
      wb(1'b0, `SPS_OFF_BUF, 8'h0);
      chk("rx byte", rows[i][15:8], rd);
    end
    chk("pins", 1, pin_out.pins_active);
    // select moved to the other pin
    wb(1'b1, `SPS_OFF_APF, 8'h02);
    wb(1'b1, `SPS_OFF_BUF, 8'h5a);
    i_master.xfer(8'hc3, 8, rx);
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    chk("unselected", 32'h0, rd);
    @(posedge clk_sys) sel_b <= 1'b1;
    i_master.xfer(8'hc3, 8, rx);
    chk("alt sdo", 8'h5a, rx);
    wb(1'b0, `SPS_OFF_BUF, 8'h0);
    chk("alt rx", 8'hc3, rd);
    // buffer write mid-byte
    wb(1'b1, `SPS_OFF_BUF, 8'h99);
    fork
      i_master.xfer(8'h0f, 8, rx);
      begin
        repeat (40) @(posedge clk_sys);
        wb(1'b1, `SPS_OFF_BUF, 8'h11);
      end
    join
    chk("write_collision_flag sdo", 8'h99, rx);
    wb(1'b0, `SPS_OFF_CTRL, 8'h0);
    chk("write_collision_flag bit", 32'ha4, rd);
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    chk("write_collision_flag irq", 32'h3, rd);
    wb(1'b1, `SPS_OFF_CTRL, 8'h24);
    wb(1'b0, `SPS_OFF_BUF, 8'h0);
    // aborted byte, then reload
    i_master.xfer(8'hff, 4, rx);
    repeat (4) @(posedge clk_sys);
    chk("released sdo", 0, pin_out.sdo_oe);
    wb(1'b1, `SPS_OFF_BUF, 8'h66);
    i_master.xfer(8'h3c, 8, rx);
    chk("reload sdo", 8'h66, rx);
    wb(1'b0, `SPS_OFF_BUF, 8'h0);
    chk("after abort", 8'h3c, rd);
    // overflow stops the port
    i_master.xfer(8'h12, 8, rx);
    i_master.xfer(8'h34, 8, rx);
    wb(1'b0, `SPS_OFF_CTRL, 8'h0);
    chk("ovf bit", 32'h64, rd);
    wb(1'b0, `SPS_OFF_BUF, 8'h0);
    chk("ovf keep", 8'h12, rd);
    i_master.xfer(8'h56, 8, rx);
    wb(1'b0, `SPS_OFF_STAT, 8'h0);
    chk("ovf halt", 32'h40, rd);
    wb(1'b1, `SPS_OFF_CTRL, 8'h24);
    // sleep, masking and wake
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    wb(1'b1, `SPS_OFF_MASK, 8'h00);
    @(posedge clk_sys) sleep_mode <= 1'b1;
    i_master.xfer(8'h77, 8, rx);
    chk("masked irq", 0, irq);
    chk("masked wake", 0, wake);
    wb(1'b1, `SPS_OFF_MASK, 8'h01);
    wb(1'b0, `SPS_OFF_BUF, 8'h0);
    chk("sleep rx", 8'h77, rd);
    chk("wake", 1, wake);
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    chk("irq clear", 0, irq);
    // frozen clock enable ignores a whole byte
    @(posedge clk_sys) ce <= 1'b0;
    i_master.xfer(8'h55, 8, rx);
    @(posedge clk_sys) ce <= 1'b1;
    wb(1'b0, `SPS_OFF_IRQ, 8'h0);
    chk("frozen", 32'h0, rd);
    // disabled port
    wb(1'b1, `SPS_OFF_CTRL, 8'h04);
    wb(1'b0, `SPS_OFF_CTRL, 8'h0);
    chk("disabled", 0, pin_out.pins_active);
    // reset in mid-run
    wb(1'b1, `SPS_OFF_CTRL, 8'h24);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    chk("reset irq", 0, irq);
    wb(1'b0, `SPS_OFF_CTRL, 8'h0);
    chk("reset ctrl", 32'h0, rd);
    chk("reset pins", 0, pin_out.pins_active);
    end_sim();
  end
endmodule
